// *** logic/sgc_pkg.sv ***
// sgc_pkg: constants and types of the stop/go bit control block.
// assumes a 200 MHz system clock and a 1.536 MHz frame-bus data clock.
package sgc_pkg;
	// system clock
	localparam int CLK_NS = 5;
	// frame bus: three channels of 32 bits at 1.536 MHz
	localparam int DCL_KHZ    = 1536;
	localparam int CH_BITS    = 32;
	localparam int FRAME_BITS = 3 * CH_BITS;
	localparam logic [6:0] SG_BIT_IDX   = 7'h5B; // channel 3 base 64 + bit 27
	localparam logic [6:0] DUP_BIT0_IDX = 7'h18; // upstream d bits, channel 1
	localparam logic [6:0] DUP_BIT1_IDX = 7'h19;
	localparam logic [6:0] BIT_LAST     = 7'h5F;
	// line operations-channel codes
	localparam logic [7:0] EOC_STOP = 8'h25;
	localparam logic [7:0] EOC_GO   = 8'h27;
	// pulse length in frames
	localparam logic [2:0] PULSE_FRAMES = 3'h4;
	// timers, in their own units and in clock cycles
	localparam int GUARD_US  = 500;
	localparam int TD_MIN_US = 7500;
	localparam int TD_MAX_US = 15000;
	localparam int GUARD_CYC  = GUARD_US * 1000 / CLK_NS;
	localparam int TD_MIN_CYC = TD_MIN_US * 1000 / CLK_NS;
	localparam int TD_MAX_CYC = TD_MAX_US * 1000 / CLK_NS;
	localparam int TMR_W      = 22;
	// register map, byte addresses
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_CMD    = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;
	// control field positions and reset value
	localparam int CTRL_PULSE  = 0;
	localparam int CTRL_LEVEL  = 1;
	localparam int CTRL_FOLLOW = 2;
	localparam logic [2:0] CTRL_RST = 3'h0;
	// command bits
	localparam int CMD_GUARD = 0;
	localparam int CMD_DELAY = 1;
	// status fields: sticky low nibble, live bits above
	localparam int ST_STOP   = 0;
	localparam int ST_GO     = 1;
	localparam int ST_GEXP   = 2;
	localparam int ST_DEXP   = 3;
	localparam int ST_SG     = 4;
	localparam int ST_DZERO  = 5;
	localparam int ST_BAC    = 6;
	localparam int ST_GRUN   = 7;
	localparam int ST_DRUN   = 8;
	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		SGC_IDLE  = 2'b00,
		SGC_HELD  = 2'b01,
		SGC_PULSE = 2'b10
	} sgc_sg_st_t;

	typedef struct packed {
		logic pulse_mode_sel;
		logic level_mode_sel;
		logic access_follow;
	} sgc_cfg_t;
endpackage

// *** logic/sgc_timer.sv ***
// sgc_timer: one-shot down counter with expiry pulse.
// assumes start and load come from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module sgc_timer #(
	parameter int W = 22
) (
	input  wire logic         clk_in,
	input  wire logic         rstn_in,
	input  wire logic         ce_in,
	input  wire logic         start_in,
	input  wire logic [W-1:0] load_in,
	output logic              running_out,
	output logic              expired_out
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         run;
		logic         exp;
	} sgc_tmr_t;

	sgc_tmr_t tmr_reg;
	sgc_tmr_t tmr_next;

	// restart on start, count down, pulse expiry at zero
	always_comb begin
		tmr_next     = tmr_reg;
		tmr_next.exp = 1'b0;
		if (start_in) begin
			tmr_next.cnt = load_in;
			tmr_next.run = 1'b1;
		end else if (tmr_reg.run) begin
			if (tmr_reg.cnt <= W'(1)) begin
				tmr_next.run = 1'b0;
				tmr_next.exp = 1'b1;
				tmr_next.cnt = '0;
			end else begin
				tmr_next.cnt = tmr_reg.cnt - W'(1);
			end
		end
	end

	// register with freeze
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			tmr_reg <= '0;
		end else if (ce_in) begin
			tmr_reg <= tmr_next;
		end
	end

	assign running_out = tmr_reg.run;
	assign expired_out = tmr_reg.exp;
endmodule // sgc_timer
`default_nettype wire

// *** logic/sgc_top.sv ***
// sgc_top: stop/go bit control on the frame bus, axi4-lite registers.
// assumes frame-bus clock, sync and data arrive asynchronously and
// the eoc strobe, terminal and sync inputs come from logic on clk_in.
//
// Behaviour
// R1: stop/go bit driven into every outgoing frame, never read back.
// R2: frame bus assumed at 1.536 MHz, three channels per frame.
// R3: pulse off: level off gives 0, level on with follow off gives 1.
// R4: pulse off, level on, follow on: bus access bit drives stop/go.
// R5: level settings: stop code sets bit to 1, go code clears it.
// R6: pulse on, level off, follow off: stop code gives 1 for 4 frames.
// R7: pulse on, level off, follow on: stop code gives 0 for 4 frames.
// R8: access follow bit reads cleared after reset.
// R9: pulse on, level on, follow off: only codes matter, access bit ignored.
// R10: all three set: access bit steers stop/go and d-channel zeroing.
// R11: behaviour qualified by the processor mode pin.
// R12: behaviour qualified by terminal mode input.
// R13: behaviour qualified by receiver synchronized input.
// R14: stop code arrival flagged to the controller.
// R15: go code arrival flagged to the controller.
// R16: software starts a 500 us guard timer and sees its expiry.
// R17: delay timer of 7.5 to 15 ms set by eoc frame position.
// R18: far end supplies bus access bit at bit 27 of channel 3.
// R19: stop/go bit placed at bit 27 of channel 3 on data out.
// R20: force-zero active replaces upstream d bits with 0.
// R21: stop/go status also shown on a dedicated pin.
// R22: status pin may differ from bus bit in undefined state.
`timescale 1ns/1ps
`default_nettype none
module sgc_top #(
	parameter int GUARD_CYC  = sgc_pkg::GUARD_CYC,
	parameter int TD_MIN_CYC = sgc_pkg::TD_MIN_CYC,
	parameter int TD_MAX_CYC = sgc_pkg::TD_MAX_CYC
) (
	input  wire logic        clk_in,
	input  wire logic        rstn_in,
	input  wire logic        ce_in,
	// axi4-lite slave
	input  wire logic [3:0]  s_axi_awaddr_in,
	input  wire logic        s_axi_awvalid_in,
	output logic             s_axi_awready_out,
	input  wire logic [31:0] s_axi_wdata_in,
	input  wire logic [3:0]  s_axi_wstrb_in,
	input  wire logic        s_axi_wvalid_in,
	output logic             s_axi_wready_out,
	output logic [1:0]       s_axi_bresp_out,
	output logic             s_axi_bvalid_out,
	input  wire logic        s_axi_bready_in,
	input  wire logic [3:0]  s_axi_araddr_in,
	input  wire logic        s_axi_arvalid_in,
	output logic             s_axi_arready_out,
	output logic [31:0]      s_axi_rdata_out,
	output logic [1:0]       s_axi_rresp_out,
	output logic             s_axi_rvalid_out,
	input  wire logic        s_axi_rready_in,
	// frame bus
	input  wire logic        dcl_in,
	input  wire logic        fsc_in,
	input  wire logic        din_in,
	input  wire logic        tx_src_in,
	output logic             dout_out,
	output logic [1:0]       d_up_out,
	output logic             d_up_valid_out,
	// qualifiers and line events
	input  wire logic        processor_mode_pin_in,
	input  wire logic        terminal_mode_in,
	input  wire logic        rx_synced_in,
	input  wire logic        eoc_valid_in,
	input  wire logic [7:0]  eoc_code_in,
	input  wire logic [2:0]  eoc_pos_in,
	// status pin and force-zero output
	output logic             stop_go_status_pin_out,
	output logic             force_d_zero_out
);
	localparam int W = sgc_pkg::TMR_W;

	// refuse zero timer lengths and delay lengths the counter cannot hold; guard length not checked against width
	if (GUARD_CYC < 1 || TD_MIN_CYC < 1 || TD_MAX_CYC < TD_MIN_CYC
			|| TD_MAX_CYC >= (1 << W)) begin : bad_timer_param
		$error("sgc_top: timer length out of range");
	end

	typedef struct packed {
		logic [3:0]          s1;     // first sync stage: dcl fsc din processor_mode_pin
		logic [3:0]          s2;
		logic                dcl_d;
		logic [6:0]          bit_no;
		logic                bac;
		logic [1:0]          dcap;
		logic [1:0]          d_up;
		logic                d_up_v;
		logic                sg_frame;
		logic                sg_pin;
		logic                dzero;
		logic                dout;
		sgc_pkg::sgc_sg_st_t st;
		logic [2:0]          pulse_cnt;
		sgc_pkg::sgc_cfg_t   cfg;
		logic [3:0]          sticky;
		logic [1:0]          tstart;
		logic                aw_held;
		logic [3:0]          aw_addr;
		logic                w_held;
		logic [31:0]         w_data;
		logic [3:0]          w_strb;
		logic                awready;
		logic                wready;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                arready;
		logic                rvalid;
		logic [31:0]         rdata;
		logic [1:0]          rresp;
	} sgc_state_t;

	localparam sgc_state_t RST = '{
		s1: 4'h0, s2: 4'h0, dcl_d: 1'b0, bit_no: 7'h0, bac: 1'b0,
		dcap: 2'h0, d_up: 2'h0, d_up_v: 1'b0, sg_frame: 1'b0,
		sg_pin: 1'b0, dzero: 1'b0, dout: 1'b0, st: sgc_pkg::SGC_IDLE,
		pulse_cnt: 3'h0, cfg: sgc_pkg::CTRL_RST, sticky: 4'h0,
		tstart: 2'h0, aw_held: 1'b0, aw_addr: 4'h0, w_held: 1'b0,
		w_data: 32'h0, w_strb: 4'h0, awready: 1'b0, wready: 1'b0,
		bvalid: 1'b0, bresp: 2'h0, arready: 1'b0, rvalid: 1'b0,
		rdata: 32'h0, rresp: 2'h0
	};

	sgc_state_t q_reg;
	sgc_state_t q_next;
	logic       grd_run;
	logic       grd_exp;
	logic       dly_run;
	logic       dly_exp;
	logic [W-1:0] dly_load;

	// register address decode, shared by read and write
	function automatic logic addr_ok(input logic [3:0] a);
		addr_ok = (a == sgc_pkg::REG_CTRL) || (a == sgc_pkg::REG_CMD)
			|| (a == sgc_pkg::REG_STATUS);
	endfunction

	// delay length from eoc frame position, min..max in seven equal steps
	localparam longint TD_STEP = (longint'(TD_MAX_CYC) - TD_MIN_CYC) / 7;
	assign dly_load = W'(longint'(TD_MIN_CYC) + TD_STEP * eoc_pos_in); // R17

	// guard timer, 500 us
	sgc_timer #(.W(W)) u_guard (
		.clk_in      (clk_in),
		.rstn_in     (rstn_in),
		.ce_in       (ce_in),
		.start_in    (q_reg.tstart[sgc_pkg::CMD_GUARD]),
		.load_in     (W'(GUARD_CYC)),
		.running_out (grd_run),
		.expired_out (grd_exp)
	);

	// eoc delay timer
	sgc_timer #(.W(W)) u_delay (
		.clk_in      (clk_in),
		.rstn_in     (rstn_in),
		.ce_in       (ce_in),
		.start_in    (q_reg.tstart[sgc_pkg::CMD_DELAY]),
		.load_in     (dly_load),
		.running_out (dly_run),
		.expired_out (dly_exp)
	);

	// whole next-state function of q_reg
	always_comb begin
		logic       dcl_rise;
		logic       dcl_fall;
		logic       active;
		logic       stop_ev;
		logic       go_ev;
		logic       sg_val;
		logic       dz_val;
		logic       do_wr;
		logic [3:0] clr;
		logic [31:0] rd;
		logic [6:0] nb;
		dcl_rise = 1'b0;
		dcl_fall = 1'b0;
		active   = 1'b0;
		stop_ev  = 1'b0;
		go_ev    = 1'b0;
		sg_val   = 1'b0;
		dz_val   = 1'b0;
		do_wr    = 1'b0;
		clr      = 4'h0;
		rd       = 32'h0;
		nb       = 7'h0;
		q_next   = q_reg;

		// two-stage sync of pins, edges from second stage only
		q_next.s1    = {dcl_in, fsc_in, din_in, processor_mode_pin_in};
		q_next.s2    = q_reg.s1;
		q_next.dcl_d = q_reg.s2[3];
		dcl_rise     = q_reg.s2[3] & ~q_reg.dcl_d;
		dcl_fall     = ~q_reg.s2[3] & q_reg.dcl_d;

		// line events and qualifiers
		stop_ev = eoc_valid_in && (eoc_code_in == sgc_pkg::EOC_STOP); // R14
		go_ev   = eoc_valid_in && (eoc_code_in == sgc_pkg::EOC_GO); // R15
		active  = q_reg.s2[0] & terminal_mode_in & rx_synced_in; // R11 R12 R13

		// stop/go state machine
		case (q_reg.st)
			sgc_pkg::SGC_IDLE: begin
				if (active && stop_ev && q_reg.cfg.pulse_mode_sel
						&& !q_reg.cfg.level_mode_sel) begin
					q_next.st        = sgc_pkg::SGC_PULSE;
					q_next.pulse_cnt = sgc_pkg::PULSE_FRAMES; // R6 R7
				end else if (active && stop_ev && q_reg.cfg.level_mode_sel) begin
					q_next.st = sgc_pkg::SGC_HELD; // R5
				end
			end
			sgc_pkg::SGC_HELD: begin
				if (!active || go_ev || !q_reg.cfg.level_mode_sel) begin
					q_next.st = sgc_pkg::SGC_IDLE; // R5
				end
			end
			sgc_pkg::SGC_PULSE: begin
				if (!active || !q_reg.cfg.pulse_mode_sel
						|| q_reg.cfg.level_mode_sel) begin
					q_next.st = sgc_pkg::SGC_IDLE;
				end else if (dcl_rise && q_reg.s2[2]) begin
					// count frames, then drop back automatically
					if (q_reg.pulse_cnt <= 3'h1) begin
						q_next.st        = sgc_pkg::SGC_IDLE; // R6 R7
						q_next.pulse_cnt = 3'h0;
					end else begin
						q_next.pulse_cnt = q_reg.pulse_cnt - 3'h1;
					end
				end
			end
			default: q_next.st = sgc_pkg::SGC_IDLE;
		endcase

		// bit value per mode
		case ({q_reg.cfg.pulse_mode_sel, q_reg.cfg.level_mode_sel})
			2'b00: sg_val = 1'b0; // R3
			2'b01: begin
				if (q_reg.cfg.access_follow) begin
					sg_val = q_reg.bac | (q_reg.st == sgc_pkg::SGC_HELD); // R4 R5
				end else begin
					sg_val = 1'b1; // R3
				end
			end
			2'b10: sg_val = (q_reg.st == sgc_pkg::SGC_PULSE)
				^ q_reg.cfg.access_follow; // R6 R7
			2'b11: begin
				if (q_reg.cfg.access_follow) begin
					sg_val = q_reg.bac | (q_reg.st == sgc_pkg::SGC_HELD); // R10
					dz_val = q_reg.bac; // R10
				end else begin
					sg_val = (q_reg.st == sgc_pkg::SGC_HELD); // R9
				end
			end
			default: sg_val = 1'b0;
		endcase
		q_next.sg_pin = sg_val; // R21 R22
		q_next.dzero  = dz_val;

		// frame bus: drive on rising dcl, sample on falling dcl
		if (dcl_rise) begin
			nb = q_reg.s2[2] ? 7'h0 :
				((q_reg.bit_no >= sgc_pkg::BIT_LAST) ? sgc_pkg::BIT_LAST
				: q_reg.bit_no + 7'h1);
			q_next.bit_no = nb; // R2
			if (q_reg.s2[2]) begin
				q_next.sg_frame = sg_val; // one value per frame
			end
			if (nb == sgc_pkg::SG_BIT_IDX) begin
				q_next.dout = q_reg.s2[2] ? sg_val : q_reg.sg_frame; // R1 R19
			end else begin
				q_next.dout = tx_src_in;
			end
		end
		q_next.d_up_v = 1'b0;
		if (dcl_fall) begin
			if (q_reg.bit_no == sgc_pkg::SG_BIT_IDX) begin
				q_next.bac = q_reg.s2[1]; // R18
			end
			if (q_reg.bit_no == sgc_pkg::DUP_BIT0_IDX) begin
				q_next.dcap[1] = q_reg.s2[1];
			end
			if (q_reg.bit_no == sgc_pkg::DUP_BIT1_IDX) begin
				q_next.d_up   = dz_val ? 2'h0 : {q_reg.dcap[1], q_reg.s2[1]}; // R20
				q_next.d_up_v = 1'b1;
			end
		end

		// axi write: address and data in either order
		q_next.tstart = 2'h0;
		if (s_axi_awvalid_in && q_reg.awready) begin
			q_next.aw_held = 1'b1;
			q_next.aw_addr = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && q_reg.wready) begin
			q_next.w_held = 1'b1;
			q_next.w_data = s_axi_wdata_in;
			q_next.w_strb = s_axi_wstrb_in;
		end
		if (q_reg.bvalid && s_axi_bready_in) begin
			q_next.bvalid = 1'b0;
		end
		if (q_reg.aw_held && q_reg.w_held && !q_reg.bvalid) begin
			do_wr          = q_reg.w_strb[0];
			q_next.aw_held = 1'b0;
			q_next.w_held  = 1'b0;
			q_next.bvalid  = 1'b1;
			q_next.bresp   = addr_ok(q_reg.aw_addr) ? sgc_pkg::RESP_OKAY
				: sgc_pkg::RESP_SLVERR;
		end
		if (do_wr && q_reg.aw_addr == sgc_pkg::REG_CTRL) begin
			q_next.cfg = {q_reg.w_data[sgc_pkg::CTRL_PULSE], q_reg.w_data[sgc_pkg::CTRL_LEVEL],
				q_reg.w_data[sgc_pkg::CTRL_FOLLOW]};
		end
		if (do_wr && q_reg.aw_addr == sgc_pkg::REG_CMD) begin
			q_next.tstart = q_reg.w_data[1:0]; // R16 R17
		end
		if (do_wr && q_reg.aw_addr == sgc_pkg::REG_STATUS) begin
			clr = q_reg.w_data[3:0];
		end
		q_next.awready = !q_next.aw_held && !q_next.bvalid;
		q_next.wready  = !q_next.w_held && !q_next.bvalid;

		// sticky flags, set wins over write-one-to-clear
		q_next.sticky = (q_reg.sticky & ~clr)
			| {dly_exp, grd_exp, go_ev, stop_ev}; // R14 R15 R16 R17

		// axi read
		rd[sgc_pkg::CTRL_PULSE]  = q_reg.cfg.pulse_mode_sel;
		rd[sgc_pkg::CTRL_LEVEL]  = q_reg.cfg.level_mode_sel;
		rd[sgc_pkg::CTRL_FOLLOW] = q_reg.cfg.access_follow; // R8
		if (q_reg.rvalid && s_axi_rready_in) begin
			q_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid_in && q_reg.arready) begin
			q_next.rvalid = 1'b1;
			q_next.rresp  = addr_ok(s_axi_araddr_in) ? sgc_pkg::RESP_OKAY
				: sgc_pkg::RESP_SLVERR;
			if (s_axi_araddr_in == sgc_pkg::REG_STATUS) begin
				rd = 32'h0;
				rd[3:0]              = q_reg.sticky;
				rd[sgc_pkg::ST_SG]   = q_reg.sg_pin;
				rd[sgc_pkg::ST_DZERO] = q_reg.dzero;
				rd[sgc_pkg::ST_BAC]  = q_reg.bac;
				rd[sgc_pkg::ST_GRUN] = grd_run;
				rd[sgc_pkg::ST_DRUN] = dly_run;
			end else if (s_axi_araddr_in != sgc_pkg::REG_CTRL) begin
				rd = 32'h0;
			end
			q_next.rdata = rd;
		end
		q_next.arready = !q_next.rvalid;
	end

	// one register for all state but the timers', frozen while ce is low
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			q_reg <= RST; // R8
		end else if (ce_in) begin
			q_reg <= q_next;
		end
	end

	// outputs straight from flip-flops
	assign s_axi_awready_out      = q_reg.awready;
	assign s_axi_wready_out       = q_reg.wready;
	assign s_axi_bresp_out        = q_reg.bresp;
	assign s_axi_bvalid_out       = q_reg.bvalid;
	assign s_axi_arready_out      = q_reg.arready;
	assign s_axi_rdata_out        = q_reg.rdata;
	assign s_axi_rresp_out        = q_reg.rresp;
	assign s_axi_rvalid_out       = q_reg.rvalid;
	assign dout_out               = q_reg.dout;
	assign d_up_out               = q_reg.d_up;
	assign d_up_valid_out         = q_reg.d_up_v;
	assign stop_go_status_pin_out = q_reg.sg_pin; // R21
	assign force_d_zero_out       = q_reg.dzero; // R20
endmodule // sgc_top
`default_nettype wire

// *** testbench/sgc_checker.sv ***
// sgc_checker: port assertions for sgc_top.
// assumes it is bound onto sgc_top; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module sgc_checker (
	input wire logic        clk_in,
	input wire logic        rstn_in,
	input wire logic        ce_in,
	input wire logic        s_axi_awvalid_in,
	input wire logic        s_axi_awready_out,
	input wire logic        s_axi_wvalid_in,
	input wire logic        s_axi_wready_out,
	input wire logic        s_axi_bvalid_out,
	input wire logic        s_axi_bready_in,
	input wire logic [1:0]  s_axi_bresp_out,
	input wire logic        s_axi_arvalid_in,
	input wire logic        s_axi_arready_out,
	input wire logic        s_axi_rvalid_out,
	input wire logic        s_axi_rready_in,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic        dout_out,
	input wire logic [1:0]  d_up_out,
	input wire logic        d_up_valid_out,
	input wire logic        stop_go_status_pin_out,
	input wire logic        force_d_zero_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	// register bus answers
	rd_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
		else $error("read answer missing");
	wr_answer_a: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
		&& s_axi_wready_out |-> ##[1:3] s_axi_bvalid_out)
		else $error("write answer missing");
	b_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in
		|=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
		else $error("write answer dropped");
	r_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in
		|=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
		else $error("read answer dropped");
	rd_block_a: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
		else $error("read taken while busy");
	wr_block_a: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
		else $error("write taken while busy");
	// frame side
	dzero_force_a: assert property (force_d_zero_out && d_up_valid_out |-> d_up_out == 2'h0)
		else $error("d bits not forced");
	upd_pulse_a: assert property (d_up_valid_out && ce_in |=> !d_up_valid_out)
		else $error("d update not a pulse");
	freeze_a: assert property (!ce_in |=> $stable(dout_out) && $stable(stop_go_status_pin_out))
		else $error("outputs moved while frozen");
	cover property (s_axi_bvalid_out && s_axi_bready_in);
	cover property (force_d_zero_out && d_up_valid_out);
	cover property ($rose(stop_go_status_pin_out));
endmodule // sgc_checker
bind sgc_top sgc_checker u_chk (.*);
`default_nettype wire

// *** testbench/sgc_frame_model.sv ***
// sgc_frame_model: frame-bus controller making clock, sync and data.
// assumes the block samples these asynchronously on its own clock.
`timescale 1ns/1ps
`default_nettype none
module sgc_frame_model (
	input  wire logic   bac_in,
	input  wire logic   dout_in,
	output logic        dcl_out,
	output logic        fsc_out,
	output logic        din_out,
	output logic        sg_out,
	output logic [15:0] frm_out
);
	int bit_n = 95;
	// free-running 80 ns bit clock, off the system clock phase
	initial begin
		dcl_out = 1'b0;
		fsc_out = 1'b0;
		din_out = 1'b0;
		sg_out = 1'b0;
		frm_out = 16'h0000;
		#1.3;
		forever #40 dcl_out = ~dcl_out;
	end
	// new bit 20 ns after a rise, clear of both sampling points
	always @(posedge dcl_out) begin
		bit_n = (bit_n == 95) ? 0 : bit_n + 1;
		#20;
		fsc_out = (bit_n == 95);
		din_out = (bit_n == 91) ? bac_in : (bit_n[0] ^ frm_out[0]);
	end
	// pick up the stop/go bit mid-bit
	always @(negedge dcl_out) begin
		if (bit_n == 91) begin
			sg_out = dout_in;
			frm_out = frm_out + 16'h0001;
		end
	end
endmodule // sgc_frame_model
`default_nettype wire

// *** testbench/stop_go_bit_control_bench.sv ***
// stop_go_bit_control_bench: self-checking bench for sgc_top.
// assumes sgc_checker bound by its file and sgc_frame_model as far end.
`timescale 1ns/1ps
`default_nettype none
module stop_go_bit_control_bench;
	localparam int GC = 50;
	localparam int TMIN = 100;
	localparam int TMAX = 170;
	typedef struct packed {
		logic [2:0] cfg;
		logic       bac;
		logic       sg;
		logic       dz;
	} sgc_row_t;
	// ctrl value, bus access bit, expected stop/go and force
	sgc_row_t rows [9] = '{6'h04, 6'h24, 6'h16, 6'h30, 6'h36, 6'h0C, 6'h2A, 6'h1C, 6'h3F};
	logic clk_in = 1'b0, rstn_in = 1'b0, ce_in = 1'b1;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata, rd_d;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [1:0] bresp, rresp, rd_r, d_up;
	logic awready, wready, bvalid, arready, rvalid, dcl, fsc, din, dout;
	logic bac = 1'b0, sg, d_up_valid, sg_pin, dz;
	logic pm = 1'b1, tm = 1'b1, rs = 1'b1, eoc_v = 1'b0;
	logic [7:0] eoc_c = 8'h00;
	logic [2:0] eoc_p = 3'h0;
	logic [15:0] frm;
	int error_cnt = 0, compares = 0, cyc = 0, n;
	sgc_top #(.GUARD_CYC(GC), .TD_MIN_CYC(TMIN), .TD_MAX_CYC(TMAX)) dut (
		.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
		.s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
		.s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
		.dcl_in(dcl), .fsc_in(fsc), .din_in(din), .tx_src_in(1'b1), .dout_out(dout),
		.d_up_out(d_up), .d_up_valid_out(d_up_valid),
		.processor_mode_pin_in(pm), .terminal_mode_in(tm), .rx_synced_in(rs),
		.eoc_valid_in(eoc_v), .eoc_code_in(eoc_c), .eoc_pos_in(eoc_p),
		.stop_go_status_pin_out(sg_pin), .force_d_zero_out(dz));
	sgc_frame_model far (.bac_in(bac), .dout_in(dout), .dcl_out(dcl), .fsc_out(fsc),
		.din_out(din), .sg_out(sg), .frm_out(frm));
	always #2.5 clk_in = ~clk_in;
	// hang guard
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 95000) begin
			error_cnt++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// write: both channels offered, each released once taken
	task automatic axi_wr(logic [3:0] a, logic [31:0] d);
		@(posedge clk_in);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_in);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		rd_r = bresp;
	endtask
	task automatic axi_rd(logic [3:0] a);
		@(posedge clk_in);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_in);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		rd_d = rdata;
		rd_r = rresp;
	endtask
	task automatic st_bit(int b, logic e);
		axi_rd(sgc_pkg::REG_STATUS);
		chk("status bit", e, rd_d[b]);
	endtask
	task automatic frames(int k);
		repeat (k) @(frm);
	endtask
	task automatic code(logic [7:0] c);
		@(posedge clk_in);
		eoc_c <= c;
		eoc_v <= 1'b1;
		@(posedge clk_in);
		eoc_v <= 1'b0;
	endtask
	// main sequence
	initial begin
		repeat (3) @(posedge clk_in);
		rstn_in <= 1'b1;
		@(posedge clk_in);
		chk("reset pin", 0, sg_pin);
		axi_rd(sgc_pkg::REG_CTRL);
		chk("ctrl reset", 0, rd_d);
		axi_rd(sgc_pkg::REG_CMD);
		chk("cmd read", 0, rd_d);
		axi_rd(4'hC);
		chk("unmapped read", sgc_pkg::RESP_SLVERR, rd_r);
		axi_wr(4'hC, 32'h7);
		chk("unmapped write", sgc_pkg::RESP_SLVERR, rd_r);
		foreach (rows[i]) begin
			axi_wr(sgc_pkg::REG_CTRL, {29'h0, rows[i].cfg});
			bac <= rows[i].bac;
			frames(3);
			chk("bus stop/go", rows[i].sg, sg);
			chk("status pin", rows[i].sg, sg_pin);
			chk("force zero", rows[i].dz, dz);
			chk("d bits", !rows[i].dz, d_up[1] ^ d_up[0]);
		end
		// level hold, access bit ignored
		axi_wr(sgc_pkg::REG_CTRL, 32'h3);
		axi_wr(sgc_pkg::REG_STATUS, 32'hF);
		code(sgc_pkg::EOC_STOP);
		frames(2);
		chk("held stop", 1, sg);
		st_bit(sgc_pkg::ST_STOP, 1'b1);
		st_bit(sgc_pkg::ST_GO, 1'b0);
		code(sgc_pkg::EOC_GO);
		frames(2);
		chk("held go", 0, sg);
		st_bit(sgc_pkg::ST_GO, 1'b1);
		// any qualifier low ignores the stop code
		for (int q = 0; q < 3; q++) begin
			@(posedge clk_in);
			{pm, tm, rs} <= ~(3'h4 >> q);
			repeat (3) @(posedge clk_in);
			code(sgc_pkg::EOC_STOP);
			frames(2);
			chk("qualified off", 0, sg);
		end
		@(posedge clk_in);
		{pm, tm, rs} <= 3'h7;
		// stop pulse of both polarities
		for (int f = 0; f < 2; f++) begin
			axi_wr(sgc_pkg::REG_CTRL, f ? 32'h5 : 32'h1);
			frames(1);
			code(sgc_pkg::EOC_STOP);
			n = 0;
			repeat (6) begin
				frames(1);
				if (sg !== f[0]) n++;
			end
			chk("pulse frames", 4, n);
		end
		// guard timer
		axi_wr(sgc_pkg::REG_STATUS, 32'hF);
		axi_wr(sgc_pkg::REG_CMD, 32'h1);
		st_bit(sgc_pkg::ST_GRUN, 1'b1);
		st_bit(sgc_pkg::ST_GEXP, 1'b0);
		repeat (GC) @(posedge clk_in);
		st_bit(sgc_pkg::ST_GEXP, 1'b1);
		// delay timer at both ends of the position range
		for (int p = 0; p < 8; p += 7) begin
			eoc_p <= p[2:0];
			axi_wr(sgc_pkg::REG_STATUS, 32'hF);
			axi_wr(sgc_pkg::REG_CMD, 32'h2);
			repeat (TMIN + (TMAX - TMIN) * p / 7 - 15) @(posedge clk_in);
			st_bit(sgc_pkg::ST_DEXP, 1'b0);
			repeat (25) @(posedge clk_in);
			st_bit(sgc_pkg::ST_DEXP, 1'b1);
		end
		// clock enable low freezes the block
		ce_in <= 1'b0;
		repeat (20) @(posedge clk_in);
		ce_in <= 1'b1;
		finish_test();
	end
endmodule // stop_go_bit_control_bench
`default_nettype wire
